/* File: sbf_defines.svh */
`ifndef SBF_DEFINES_SVH
`define SBF_DEFINES_SVH

// Register byte addresses
`define SBF_ADR_DIV 8'h00
`define SBF_ADR_FRAC 8'h04
`define SBF_ADR_FIFO 8'h08
`define SBF_ADR_MODE 8'h0C
`define SBF_ADR_STAT 8'h10

// Reset values
`define SBF_RST_DIV 8'h00
`define SBF_RST_FRAC 8'h00
`define SBF_RST_FIFO 8'h00
`define SBF_RST_MODE 8'h00

// Divider control fields
`define SBF_DIV_N_LSB 0
`define SBF_DIV_CK_LSB 4
`define SBF_DIV_FRAC_BIT 6

// FIFO setup fields
`define SBF_FIFO_EN_BIT 0
`define SBF_FIFO_AUTO_BIT 1
`define SBF_FIFO_RECEIVE_FIFO_IRQ_ENABLE_BIT 2
`define SBF_FIFO_TRANSMIT_FIFO_IRQ_ENABLE_BIT 3
`define SBF_FIFO_RECEIVE_DEPTH_SELECT_BIT 4

// Channel mode fields
`define SBF_MODE_DPX_LSB 0
`define SBF_MODE_RIL_LSB 2
`define SBF_MODE_RXE_BIT 4
`define SBF_MODE_TXE_BIT 5

// Divider and FIFO sizes
`define SBF_N_ZERO_DIV 5'h10
`define SBF_FRAC_BASE 5'h10
`define SBF_FIFO_FULL_SIZE 3'h4
`define SBF_FIFO_HALF_SIZE 3'h2

`endif

/* File: sbf_pkg.sv */
package sbf_pkg;

    typedef enum logic [1:0] {
        SBF_DPX_OFF = 2'h0,
        SBF_DPX_RX = 2'h1,
        SBF_DPX_FULL = 2'h3,
        SBF_DPX_TX = 2'h2
    } sbf_duplex_t;

    typedef enum logic {
        SBF_BUS_IDLE = 1'h0,
        SBF_BUS_ACK = 1'h1
    } sbf_bus_st_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [3:0] acc;
        logic tick;
        logic [4:0] gap;
    } sbf_baud_st_t;

    typedef struct packed {
        sbf_bus_st_t bus;
        logic [7:0] rdata;
        logic frac_en;
        logic [1:0] clk_src;
        logic [3:0] n_code;
        logic [3:0] k;
        logic receive_depth_select;
        logic transmit_fifo_irq_enable;
        logic receive_fifo_irq_enable;
        logic auto_dis;
        logic fifo_en;
        sbf_duplex_t duplex;
        logic [1:0] receive_fill_level;
        logic rxe;
        logic txe;
        logic [2:0] tx_prev;
    } sbf_top_st_t;

endpackage

/* File: sbf_baud_if.sv */
`timescale 1ns/1ps
interface sbf_baud_if;
    logic [1:0] clk_src;
    logic [3:0] n_code;
    logic frac_en;
    logic [3:0] k;
    logic baud_tick;
    modport ctrl (output clk_src, output n_code, output frac_en, output k, input baud_tick);
    modport gen (input clk_src, input n_code, input frac_en, input k, output baud_tick);
endinterface // sbf_baud_if

/* File: sbf_baud_gen.sv */
`timescale 1ns/1ps
`include "sbf_defines.svh"
module sbf_baud_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Configuration and output tick
    sbf_baud_if.gen bif,
    // Prescaled ticks T1, T4, T16, T64
    input wire logic [3:0] tick_in
);
    import sbf_pkg::*;

    sbf_baud_st_t st_q;
    sbf_baud_st_t st_d;
    logic tick_sel;
    logic [4:0] div;
    logic [4:0] sum;
    logic extra;

    always_comb
    begin
        tick_sel = tick_in[bif.clk_src];
        div = (bif.n_code == 4'h0) ? `SBF_N_ZERO_DIV : {1'b0, bif.n_code};
        sum = 5'({1'b0, st_q.acc} + (`SBF_FRAC_BASE - {1'b0, bif.k}));
        extra = bif.frac_en & sum[4];
        st_d = st_q;
        st_d.tick = 1'b0;
        if (tick_sel)
        begin
            st_d.gap = 5'(st_q.gap + 5'h01);
            if (st_q.cnt == 5'h00)
            begin
                st_d.tick = 1'b1;
                st_d.gap = 5'h01;
                st_d.cnt = 5'(div - 5'h01 + {4'h0, extra});
                if (bif.frac_en)
                begin
                    st_d.acc = sum[3:0];
                end
            end
            else
            begin
                st_d.cnt = 5'(st_q.cnt - 5'h01);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign bif.baud_tick = st_q.tick;

    property p_tick_cause;
        @(posedge ref_clk) disable iff (!resetn)
        bif.baud_tick |-> $past(tick_in[bif.clk_src]);
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("baud tick without source tick");

    property p_int_period;
        @(posedge ref_clk) disable iff (!resetn)
        (tick_sel && st_q.cnt == 5'h00 && !bif.frac_en)
        |-> (st_d.cnt == 5'(div - 5'h01) && st_q.gap <= 5'h11);
    endproperty
    a_int_period: assert property (p_int_period) else $error("integer period wrong");

    property p_frac_period;
        @(posedge ref_clk) disable iff (!resetn)
        (tick_sel && st_q.cnt == 5'h00 && bif.frac_en) |-> (st_d.cnt == div || st_d.cnt == div - 5'h01);
    endproperty
    a_frac_period: assert property (p_frac_period) else $error("fractional period wrong");

endmodule // sbf_baud_gen

/* File: sbf_fifo_split.sv */
`timescale 1ns/1ps
`include "sbf_defines.svh"
module sbf_fifo_split (
    // Configuration
    input wire logic fifo_en,
    input wire sbf_pkg::sbf_duplex_t duplex,
    input wire logic receive_depth_select,
    input wire logic [1:0] receive_fill_level,
    // Fill counts from engines
    input wire logic [2:0] rx_count,
    input wire logic [2:0] tx_count,
    // Derived sizes and conditions
    output logic [2:0] rx_size,
    output logic [2:0] tx_size,
    output logic [2:0] rx_fill,
    output logic [2:0] rx_depth,
    output logic rx_full,
    output logic tx_empty
);
    import sbf_pkg::*;

    always_comb
    begin
        rx_size = 3'h0;
        tx_size = 3'h0;
        if (fifo_en)
        begin
            case (duplex)
                SBF_DPX_RX: rx_size = `SBF_FIFO_FULL_SIZE;
                SBF_DPX_TX: tx_size = `SBF_FIFO_FULL_SIZE;
                SBF_DPX_FULL:
                begin
                    rx_size = `SBF_FIFO_HALF_SIZE;
                    tx_size = `SBF_FIFO_HALF_SIZE;
                end
                default:
                begin
                    rx_size = 3'h0;
                    tx_size = 3'h0;
                end
            endcase
        end
        if (duplex == SBF_DPX_FULL)
        begin
            rx_fill = receive_fill_level[0] ? 3'h1 : 3'h2;
        end
        else
        begin
            rx_fill = (receive_fill_level == 2'h0) ? 3'h4 : {1'b0, receive_fill_level};
        end
        rx_depth = receive_depth_select ? rx_fill : rx_size;
        rx_full = (rx_size != 3'h0) && (rx_count >= rx_depth);
        tx_empty = (tx_count == 3'h0);
    end

endmodule // sbf_fifo_split

/* File: sbf_top.sv */
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "sbf_defines.svh"
// Overview of operation
// - Clock source code picks tick T1, T4, T16 or T64.
// - Divisor N is the code value; code zero divides by sixteen.
// - Fraction off divides by N; on divides by N plus (16-K)/16.
// - FIFO enabled: four bytes RX, four TX, or two each.
// - Receive size select limits receive depth to fill level.
// - Transmit FIFO interrupt enable gates transmit interrupts while the transmit FIFO is in use.
// - Receive FIFO interrupt enable gates receive interrupts while the receive FIFO is in use.
// - Auto-disable in RX half duplex clears receive enable when full.
// - Auto-disable in TX half duplex clears transmit enable on empty.
// - Auto-disable in full duplex clears both on either condition.
// - Transmit FIFO always uses its whole configured size.
// - Duplex field picks split; code zero prohibits transfer.
// - Full duplex ignores upper fill-level bit; one or two bytes.
module sbf_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Prescaled ticks T1, T4, T16, T64
    input wire logic [3:0] tick_in,
    // Engine fill counts and interrupt requests
    input wire logic [2:0] rx_count,
    input wire logic [2:0] tx_count,
    input wire logic rx_irq_in,
    input wire logic tx_irq_in,
    // Channel control out
    output logic baud_tick,
    output logic receive_enable,
    output logic transmit_enable,
    output logic [1:0] duplex_select,
    output logic [2:0] rx_fifo_depth,
    output logic [2:0] tx_fifo_depth,
    output logic rx_irq,
    output logic tx_irq
);
    import sbf_pkg::*;

    sbf_top_st_t st_q;
    sbf_top_st_t st_d;
    sbf_baud_if bif ();
    logic req;
    logic wr_go;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;
    logic [2:0] rx_size;
    logic [2:0] tx_size;
    logic [2:0] rx_fill;
    logic [2:0] rx_depth;
    logic rx_full;
    logic tx_empty;
    logic tx_became_empty;
    logic rx_fifo_on;
    logic tx_fifo_on;
    logic auto_rx;
    logic auto_tx;

    sbf_baud_gen u_baud (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .bif(bif.gen),
        .tick_in(tick_in)
    );

    sbf_fifo_split u_split (
        .fifo_en(st_q.fifo_en),
        .duplex(st_q.duplex),
        .receive_depth_select(st_q.receive_depth_select),
        .receive_fill_level(st_q.receive_fill_level),
        .rx_count(rx_count),
        .tx_count(tx_count),
        .rx_size(rx_size),
        .tx_size(tx_size),
        .rx_fill(rx_fill),
        .rx_depth(rx_depth),
        .rx_full(rx_full),
        .tx_empty(tx_empty)
    );

    assign bif.clk_src = st_q.clk_src;
    assign bif.n_code = st_q.n_code;
    assign bif.frac_en = st_q.frac_en;
    assign bif.k = st_q.k;

    // Read multiplexer
    always_comb
    begin
        case (wb_adr_i)
            `SBF_ADR_DIV: rd_mux = {1'b0, st_q.frac_en, st_q.clk_src, st_q.n_code};
            `SBF_ADR_FRAC: rd_mux = {4'h0, st_q.k};
            `SBF_ADR_FIFO: rd_mux = {3'h0, st_q.receive_depth_select, st_q.transmit_fifo_irq_enable, st_q.receive_fifo_irq_enable,
                                      st_q.auto_dis, st_q.fifo_en};
            `SBF_ADR_MODE: rd_mux = {2'h0, st_q.txe, st_q.rxe, st_q.receive_fill_level, st_q.duplex};
            `SBF_ADR_STAT: rd_mux = {rx_full, tx_size, 1'b0, rx_depth};
            default: rd_mux = 8'h00;
        endcase
    end

    // FIFO and auto-disable conditions
    always_comb
    begin
        rx_fifo_on = st_q.fifo_en & st_q.duplex[0];
        tx_fifo_on = st_q.fifo_en & st_q.duplex[1];
        tx_became_empty = tx_fifo_on && tx_empty && (st_q.tx_prev != 3'h0);
        auto_rx = 1'b0;
        auto_tx = 1'b0;
        if (st_q.auto_dis && st_q.fifo_en)
        begin
            case (st_q.duplex)
                SBF_DPX_RX: auto_rx = rx_full;
                SBF_DPX_TX: auto_tx = tx_became_empty;
                SBF_DPX_FULL:
                begin
                    auto_rx = rx_full | tx_became_empty;
                    auto_tx = rx_full | tx_became_empty;
                end
                default:
                begin
                    auto_rx = 1'b0;
                    auto_tx = 1'b0;
                end
            endcase
        end
    end

    // Bus handshake and register update
    always_comb
    begin
        req = wb_cyc_i & wb_stb_i;
        wr_go = req & wb_we_i & wb_sel_i[0] & (st_q.bus == SBF_BUS_ACK);
        wbyte = wb_dat_i[7:0];
        st_d = st_q;
        st_d.tx_prev = tx_count;
        case (st_q.bus)
            SBF_BUS_IDLE:
            begin
                if (req)
                begin
                    st_d.bus = SBF_BUS_ACK;
                    st_d.rdata = rd_mux;
                end
            end
            SBF_BUS_ACK: st_d.bus = SBF_BUS_IDLE;
            default: st_d.bus = SBF_BUS_IDLE;
        endcase
        if (wr_go)
        begin
            case (wb_adr_i)
                `SBF_ADR_DIV:
                begin
                    st_d.n_code = wbyte[`SBF_DIV_N_LSB +: 4];
                    st_d.clk_src = wbyte[`SBF_DIV_CK_LSB +: 2];
                    st_d.frac_en = wbyte[`SBF_DIV_FRAC_BIT];
                end
                `SBF_ADR_FRAC: st_d.k = wbyte[3:0];
                `SBF_ADR_FIFO:
                begin
                    st_d.fifo_en = wbyte[`SBF_FIFO_EN_BIT];
                    st_d.auto_dis = wbyte[`SBF_FIFO_AUTO_BIT];
                    st_d.receive_fifo_irq_enable = wbyte[`SBF_FIFO_RECEIVE_FIFO_IRQ_ENABLE_BIT];
                    st_d.transmit_fifo_irq_enable = wbyte[`SBF_FIFO_TRANSMIT_FIFO_IRQ_ENABLE_BIT];
                    st_d.receive_depth_select = wbyte[`SBF_FIFO_RECEIVE_DEPTH_SELECT_BIT];
                end
                `SBF_ADR_MODE:
                begin
                    st_d.duplex = sbf_duplex_t'(wbyte[`SBF_MODE_DPX_LSB +: 2]);
                    st_d.receive_fill_level = wbyte[`SBF_MODE_RIL_LSB +: 2];
                    st_d.rxe = wbyte[`SBF_MODE_RXE_BIT];
                    st_d.txe = wbyte[`SBF_MODE_TXE_BIT];
                end
                default: st_d.rdata = st_q.rdata;
            endcase
        end
        // Auto clear wins over a software write
        if (auto_rx)
        begin
            st_d.rxe = 1'b0;
        end
        if (auto_tx)
        begin
            st_d.txe = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs
    assign wb_ack_o = (st_q.bus == SBF_BUS_ACK);
    assign wb_dat_o = {24'h000000, st_q.rdata};
    assign baud_tick = bif.baud_tick;
    assign receive_enable = st_q.rxe;
    assign transmit_enable = st_q.txe;
    assign duplex_select = st_q.duplex;
    assign rx_fifo_depth = rx_depth;
    assign tx_fifo_depth = tx_size;
    assign rx_irq = rx_irq_in & (~rx_fifo_on | st_q.receive_fifo_irq_enable);
    assign tx_irq = tx_irq_in & (~tx_fifo_on | st_q.transmit_fifo_irq_enable);

    property p_ack_one;
        @(posedge ref_clk) disable iff (!resetn)
        (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle");

    property p_split_half;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.fifo_en && (st_q.duplex == SBF_DPX_RX || st_q.duplex == SBF_DPX_TX))
        |-> (rx_size + tx_size == 3'h4) && (st_q.duplex == SBF_DPX_RX) == (rx_size == 3'h4);
    endproperty
    a_split_half: assert property (p_split_half) else $error("half duplex split wrong");

    property p_split_full;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.fifo_en && st_q.duplex == SBF_DPX_FULL) |-> (rx_size == 3'h2 && tx_size == 3'h2);
    endproperty
    a_split_full: assert property (p_split_full) else $error("full duplex split wrong");

    property p_split_off;
        @(posedge ref_clk) disable iff (!resetn)
        (!st_q.fifo_en || st_q.duplex == SBF_DPX_OFF) |-> (rx_size == 3'h0 && tx_size == 3'h0);
    endproperty
    a_split_off: assert property (p_split_off) else $error("FIFO sized while off");

    property p_rx_depth;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.receive_depth_select && st_q.fifo_en && st_q.duplex == SBF_DPX_RX && st_q.receive_fill_level == 2'h3)
        |-> rx_fifo_depth == 3'h3;
    endproperty
    a_rx_depth: assert property (p_rx_depth) else $error("receive depth not fill level");

    property p_full_ril;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.duplex == SBF_DPX_FULL) |-> (rx_fill == (st_q.receive_fill_level[0] ? 3'h1 : 3'h2));
    endproperty
    a_full_ril: assert property (p_full_ril) else $error("upper fill bit not ignored");

    property p_tx_gate;
        @(posedge ref_clk) disable iff (!resetn)
        (tx_fifo_on && tx_irq_in) |-> (tx_irq == st_q.transmit_fifo_irq_enable);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("transmit irq gate wrong");

    property p_rx_gate;
        @(posedge ref_clk) disable iff (!resetn)
        (rx_fifo_on && rx_irq_in) |-> (rx_irq == st_q.receive_fifo_irq_enable);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("receive irq gate wrong");

    property p_auto_rx;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.auto_dis && st_q.fifo_en && st_q.duplex == SBF_DPX_RX && rx_full)
        |=> !receive_enable && $stable(transmit_enable);
    endproperty
    a_auto_rx: assert property (p_auto_rx) else $error("receive not auto disabled");

    property p_auto_tx;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.auto_dis && st_q.fifo_en && st_q.duplex == SBF_DPX_TX
            && $past(tx_count) != 3'h0 && tx_count == 3'h0)
        |=> !transmit_enable;
    endproperty
    a_auto_tx: assert property (p_auto_tx) else $error("transmit not auto disabled");

    property p_auto_full;
        @(posedge ref_clk) disable iff (!resetn)
        (st_q.auto_dis && st_q.fifo_en && st_q.duplex == SBF_DPX_FULL
            && (rx_full || tx_became_empty))
        |=> !transmit_enable && !receive_enable;
    endproperty
    a_auto_full: assert property (p_auto_full) else $error("full duplex not auto disabled");

    property p_tx_whole;
        @(posedge ref_clk) disable iff (!resetn)
        (tx_fifo_on && st_q.receive_depth_select) |-> (tx_fifo_depth == (st_q.duplex[0] ? 3'h2 : 3'h4));
    endproperty
    a_tx_whole: assert property (p_tx_whole) else $error("transmit depth limited");

endmodule // sbf_top

/* File: sbf_engine_model.sv */
`timescale 1ns/1ps
module sbf_engine_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Prescaled tick pulses
    output logic [3:0] tick_in
);
    logic [7:0] pre_q;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            pre_q <= 8'h00;
        else
            pre_q <= pre_q + 8'h01;
    end

    assign tick_in[0] = resetn && (pre_q[0] == 1'h1);
    assign tick_in[1] = resetn && (pre_q[2:0] == 3'h7);
    assign tick_in[2] = resetn && (pre_q[4:0] == 5'h1F);
    assign tick_in[3] = resetn && (pre_q[6:0] == 7'h7F);
endmodule // sbf_engine_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "sbf_defines.svh"
module testbench;
    logic ref_clk;
    logic resetn;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] tick_in;
    logic [2:0] rx_count;
    logic [2:0] tx_count;
    logic rx_irq_in;
    logic tx_irq_in;
    logic baud_tick;
    logic receive_enable;
    logic transmit_enable;
    logic [1:0] duplex_select;
    logic [2:0] rx_fifo_depth;
    logic [2:0] tx_fifo_depth;
    logic rx_irq;
    logic tx_irq;
    int fails = 0;
    int comparisons = 0;
    int ticks = 0;

    sbf_top DUT (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tick_in(tick_in),
        .rx_count(rx_count), .tx_count(tx_count), .rx_irq_in(rx_irq_in),
        .tx_irq_in(tx_irq_in), .baud_tick(baud_tick), .receive_enable(receive_enable),
        .transmit_enable(transmit_enable), .duplex_select(duplex_select),
        .rx_fifo_depth(rx_fifo_depth), .tx_fifo_depth(tx_fifo_depth), .rx_irq(rx_irq),
        .tx_irq(tx_irq));

    sbf_engine_model engine (.ref_clk(ref_clk), .resetn(resetn), .tick_in(tick_in));

    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
        input logic [3:0] sel, output logic [7:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, wd};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
            fails++;
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] rd;
        bus(1'b1, adr, d, 4'hF, rd);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] rd;
        bus(1'b0, adr, 8'h00, 4'hF, rd);
        check(what, 32'(rd), 32'(exp));
    endtask

    task automatic span(input int p, output logic [31:0] cyc);
        int t;
        int n;
        t = 0;
        n = 0;
        cyc = 32'h0;
        while (t < p + 2 && n < 6000)
        begin
            @(posedge ref_clk);
            n++;
            if (t >= 2)
                cyc++;
            if (baud_tick === 1'b1)
                t++;
        end
    endtask

    task automatic t_regs();
        logic [7:0] rd;
        rd_chk("div reset", `SBF_ADR_DIV, 8'h00);
        rd_chk("frac reset", `SBF_ADR_FRAC, 8'h00);
        rd_chk("fifo reset", `SBF_ADR_FIFO, 8'h00);
        rd_chk("mode reset", `SBF_ADR_MODE, 8'h00);
        wr(`SBF_ADR_FRAC, 8'hFF);
        wr(`SBF_ADR_DIV, 8'h7F);
        wr(`SBF_ADR_FIFO, 8'h1F);
        rd_chk("div rw", `SBF_ADR_DIV, 8'h7F);
        rd_chk("frac rw", `SBF_ADR_FRAC, 8'h0F);
        rd_chk("fifo rw", `SBF_ADR_FIFO, 8'h1F);
        bus(1'b1, `SBF_ADR_FIFO, 8'h00, 4'h0, rd);
        rd_chk("fifo no sel", `SBF_ADR_FIFO, 8'h1F);
        rd_chk("unmapped", 8'h40, 8'h00);
        wr(`SBF_ADR_DIV, 8'h00);
        wr(`SBF_ADR_FIFO, 8'h00);
    endtask

    task automatic t_baud();
        logic [7:0] dv [7] = '{8'h03, 8'h00, 8'h01, 8'h0F, 8'h12, 8'h22, 8'h32};
        logic [31:0] ex [7] = '{32'h0C, 32'h40, 32'h04, 32'h3C, 32'h20, 32'h80, 32'h200};
        logic [31:0] c;
        wr(`SBF_ADR_FRAC, 8'h0C);
        wr(`SBF_ADR_DIV, 8'h42);
        span(16, c);
        check("frac k12", c, 32'h48);
        wr(`SBF_ADR_DIV, 8'h00);
        wr(`SBF_ADR_FRAC, 8'h01);
        wr(`SBF_ADR_DIV, 8'h4F);
        span(16, c);
        check("frac k1", c, 32'h1FE);
        for (int i = 0; i < 7; i++)
        begin
            wr(`SBF_ADR_DIV, dv[i]);
            span(2, c);
            check("baud period", c, ex[i]);
        end
    endtask

    task automatic t_split();
        logic [2:0] rxd [4] = '{3'h0, 3'h4, 3'h0, 3'h2};
        logic [2:0] txd [4] = '{3'h0, 3'h0, 3'h4, 3'h2};
        logic [2:0] hf [4] = '{3'h4, 3'h1, 3'h2, 3'h3};
        logic [2:0] ff [4] = '{3'h2, 3'h1, 3'h2, 3'h1};
        wr(`SBF_ADR_FIFO, 8'h01);
        for (int d = 0; d < 4; d++)
        begin
            wr(`SBF_ADR_MODE, 8'(d));
            check("duplex", 32'(duplex_select), 32'(d));
            check("rx depth", 32'(rx_fifo_depth), 32'(rxd[d]));
            check("tx depth", 32'(tx_fifo_depth), 32'(txd[d]));
        end
        wr(`SBF_ADR_FIFO, 8'h11);
        for (int r = 0; r < 4; r++)
        begin
            wr(`SBF_ADR_MODE, 8'(r * 4 + 1));
            check("rx fill half", 32'(rx_fifo_depth), 32'(hf[r]));
            wr(`SBF_ADR_MODE, 8'(r * 4 + 3));
            check("rx fill full", 32'(rx_fifo_depth), 32'(ff[r]));
            check("tx full dpx", 32'(tx_fifo_depth), 32'h2);
        end
        rd_chk("status", `SBF_ADR_STAT, 8'h21);
    endtask

    task automatic t_irq();
        rx_irq_in <= 1'b1;
        tx_irq_in <= 1'b1;
        wr(`SBF_ADR_MODE, 8'h03);
        wr(`SBF_ADR_FIFO, 8'h01);
        check("rx irq off", 32'(rx_irq), 32'h0);
        check("tx irq off", 32'(tx_irq), 32'h0);
        wr(`SBF_ADR_FIFO, 8'h05);
        check("rx irq on", 32'(rx_irq), 32'h1);
        check("tx irq still off", 32'(tx_irq), 32'h0);
        wr(`SBF_ADR_FIFO, 8'h09);
        check("rx irq masked", 32'(rx_irq), 32'h0);
        check("tx irq on", 32'(tx_irq), 32'h1);
        wr(`SBF_ADR_FIFO, 8'h00);
        check("rx irq raw", 32'(rx_irq), 32'h1);
        check("tx irq raw", 32'(tx_irq), 32'h1);
        rx_irq_in <= 1'b0;
        tx_irq_in <= 1'b0;
        @(posedge ref_clk);
        check("tx irq idle", 32'(tx_irq), 32'h0);
    endtask

    task automatic t_auto();
        wr(`SBF_ADR_FIFO, 8'h01);
        wr(`SBF_ADR_MODE, 8'h11);
        rx_count <= 3'h4;
        repeat (3) @(posedge ref_clk);
        check("rxe no auto", 32'(receive_enable), 32'h1);
        rx_count <= 3'h0;
        wr(`SBF_ADR_FIFO, 8'h03);
        rx_count <= 3'h3;
        repeat (3) @(posedge ref_clk);
        check("rxe below", 32'(receive_enable), 32'h1);
        rx_count <= 3'h4;
        repeat (3) @(posedge ref_clk);
        check("rxe full", 32'(receive_enable), 32'h0);
        rx_count <= 3'h0;
        tx_count <= 3'h2;
        wr(`SBF_ADR_MODE, 8'h22);
        check("txe set", 32'(transmit_enable), 32'h1);
        tx_count <= 3'h0;
        repeat (3) @(posedge ref_clk);
        check("txe empty", 32'(transmit_enable), 32'h0);
        wr(`SBF_ADR_MODE, 8'h33);
        check("both set", 32'({receive_enable, transmit_enable}), 32'h3);
        rx_count <= 3'h2;
        repeat (3) @(posedge ref_clk);
        check("both rx full", 32'({receive_enable, transmit_enable}), 32'h0);
        rx_count <= 3'h0;
        tx_count <= 3'h1;
        wr(`SBF_ADR_MODE, 8'h33);
        tx_count <= 3'h0;
        repeat (3) @(posedge ref_clk);
        check("both tx empty", 32'({receive_enable, transmit_enable}), 32'h0);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever
            #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        ticks++;
        if (ticks == 40000)
        begin
            fails++;
            wrap_up();
        end
    end

    initial
    begin
        resetn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        rx_count = 3'h0;
        tx_count = 3'h0;
        rx_irq_in = 1'b0;
        tx_irq_in = 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_baud();
        t_split();
        t_irq();
        t_auto();
        wrap_up();
    end
endmodule // testbench
